// *** rtl/vsx_pkg.sv ***
// Shared constants for the vector select and external interrupt block
package vsx_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] VSX_OFS_MCU_CONTROL = 8'h00;
  localparam logic [7:0] VSX_OFS_SENSE_CTRL  = 8'h01;
  localparam logic [7:0] VSX_OFS_IRQ_ENABLE  = 8'h02;
  localparam logic [7:0] VSX_OFS_IRQ_FLAGS   = 8'h03;
  localparam logic [7:0] VSX_OFS_PC_MASK0    = 8'h04;
  localparam logic [7:0] VSX_OFS_PC_MASK1    = 8'h05;
  localparam logic [7:0] VSX_OFS_PC_MASK2    = 8'h06;
  localparam logic [7:0] VSX_OFS_PC_MASK3    = 8'h07;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int VSX_BIT_UNLOCK     = 0;  // vector_change_unlock
  localparam int VSX_BIT_SELECT     = 1;  // vector_base_select
  localparam int VSX_BIT_DED_ENABLE = 0;  // dedicated line enable / flag
  localparam int VSX_BIT_GRP_BASE   = 4;  // group 0 enable / flag, groups up
  localparam int VSX_NUM_GROUPS     = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  VSX_RST_BYTE = 8'h00;
  localparam logic [15:0] VSX_APP_BASE = 16'h0000;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam logic [2:0] VSX_UNLOCK_CYCLES = 3'h4;

  // ****************************************************************
  // Sense modes of the dedicated line
  // ****************************************************************
  typedef enum logic [1:0] {
    VSX_SENSE_LOW     = 2'h0,
    VSX_SENSE_ANY     = 2'h1,
    VSX_SENSE_FALLING = 2'h2,
    VSX_SENSE_RISING  = 2'h3
  } vsx_sense_e;

  // Interrupt request index toward the core
  localparam logic [2:0] VSX_ID_DEDICATED = 3'h0;

endpackage : vsx_pkg

// *** rtl/vsx_unlock_if.sv ***
// Handshake between the register file and the unlock window timer
`timescale 1ns/1ps
interface vsx_unlock_if;
  logic arm;      // Write of one to the unlock bit
  logic sel_wr;   // Select written while unlocked
  logic retire;   // Core retired an instruction
  logic armed;    // Unlock bit as stored
  logic blocking; // Interrupts held off

  modport ctl (output arm, output sel_wr, output retire, input armed, input blocking);
  modport tmr (input arm, input sel_wr, input retire, output armed, output blocking);
endinterface : vsx_unlock_if

// *** rtl/vsx_unlock.sv ***
// Unlock window timer and interrupt hold-off for vector moves
`timescale 1ns/1ps
module vsx_unlock
  import vsx_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register file side
  vsx_unlock_if.tmr uif
);

  logic [2:0] cnt_reg;
  logic       armed_reg;
  logic       post_reg;

  // Unlock bit lives four cycles unless the select write ends it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
      cnt_reg   <= 3'h0;
    end else if (uif.arm) begin
      armed_reg <= 1'b1;
      cnt_reg   <= VSX_UNLOCK_CYCLES;
    end else if (uif.sel_wr) begin
      armed_reg <= 1'b0;
      cnt_reg   <= 3'h0;
    end else if (armed_reg) begin
      cnt_reg   <= cnt_reg - 3'h1;
      armed_reg <= (cnt_reg != 3'h1);
    end
  end

  // Hold-off after the select write lasts through the next instruction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      post_reg <= 1'b0;
    end else if (uif.sel_wr) begin
      post_reg <= 1'b1;
    end else if (uif.retire) begin
      post_reg <= 1'b0;
    end
  end

  // Blocking starts combinationally in the arming cycle itself
  assign uif.armed    = armed_reg;
  assign uif.blocking = uif.arm | armed_reg | post_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_unlock_arms: assert property (@(posedge clock) disable iff (!rst_n)
    uif.arm |=> uif.armed && uif.blocking)
    else $error("unlock bit not set after arming write");
  chk_unlock_holds: assert property (@(posedge clock) disable iff (!rst_n)
    uif.arm ##1 (!uif.arm && !uif.sel_wr)[*4] |-> uif.armed)
    else $error("unlock window ended early");
  chk_unlock_expiry: assert property (@(posedge clock) disable iff (!rst_n)
    uif.arm ##1 (!uif.arm && !uif.sel_wr)[*4] |=> !uif.armed)
    else $error("unlock window not closed after four cycles");

endmodule : vsx_unlock

// *** rtl/vsx_pc_group.sv ***
// Masked change detector for one group of pin-change lines
`timescale 1ns/1ps
module vsx_pc_group
  import vsx_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Pins and mask
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic [WIDTH-1:0] mask,
  // Change event
  output logic                  hit
);

  logic [WIDTH-1:0] prev_reg;
  logic             valid_reg;

  // Runs on the core clock, never gated by the I/O clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg  <= '0;
      valid_reg <= 1'b0;
    end else begin
      prev_reg  <= pins;
      valid_reg <= 1'b1;
    end
  end

  // First sample after reset is only a baseline, not a change
  assign hit = valid_reg & (|((pins ^ prev_reg) & mask));

endmodule : vsx_pc_group

// *** rtl/vsx_irq_front.sv ***
// Interrupt front end: vector placement, dedicated line and pin-change groups
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Function
// - Interrupts blocked from unlock until after the instruction following select write.
// - Without a select write, blocking ends after exactly four cycles.
// - Automatic blocking never touches the global interrupt enable.
// - Boot vectors plus app-side lock: no interrupts while running application code.
// - App vectors plus boot-side lock: no interrupts while running boot code.
// - Select zero means vectors at flash start, one means boot section start.
// - Unlock bit self-clears four cycles after set or on select write.
// - Pin activity triggers interrupts even when pins are driven as outputs.
// - Group one watches lines 15 to 8, group zero lines 7 to 0.
// - Per-group masks choose which lines feed each group.
// - Pin-change detection needs no I/O clock and can wake from sleep.
// - Dedicated line triggers on falling edge, rising edge or low level.
// - Level mode requests continuously while the pin stays low.
// - Edge detection on the dedicated line runs on the I/O clock.
// - Low-level detection needs no I/O clock and can wake from sleep.
// - I/O clock stops in every sleep mode except idle.
// - Level gone before start-up ends: wake completes, no level interrupt.
// - Sense field: 00 low, 01 any change, 10 falling, 11 rising.
// - Edge modes catch every pulse longer than one clock period while the I/O clock runs.
// - Flags set on trigger, clear on service entry or write of one.
// - In level mode the dedicated flag is held at zero.
module vsx_irq_front
  import vsx_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // External pins
  input  wire logic        dedicated_ext_irq_line,
  input  wire logic [30:0] pin_change_inputs,
  // Fuses and lock bits (high means programmed)
  input  wire logic        app_side_lock_bit,
  input  wire logic        boot_side_lock_bit,
  input  wire logic [15:0] boot_section_base,
  // Sleep control
  input  wire logic        sleep_active,
  input  wire logic        sleep_is_idle,
  input  wire logic        wake_startup_busy,
  output logic             io_clk_en,
  output logic             wake_req,
  // Core interrupt sequencer
  input  wire logic        global_irq_enable,
  input  wire logic        exec_in_boot,
  input  wire logic        instr_retire,
  input  wire logic        irq_ack,
  input  wire logic [2:0]  irq_ack_id,
  output logic      [4:0]  irq_req,
  output logic             irq_blocked,
  output logic      [15:0] vector_base
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic       vector_sel_reg;
  vsx_sense_e sense_reg;
  logic [4:0] enable_reg;              // Bit 0 dedicated, 1..4 groups
  logic [4:0] flag_reg;                // Same layout as enable_reg
  logic [4:0] flag_next;
  logic [7:0] mask_reg [VSX_NUM_GROUPS];
  logic [7:0] rdata_reg;
  logic [7:0] rd_mux;

  // Dedicated line sampling
  logic       pin_smp_reg;
  logic       pin_prev_reg;
  logic       smp_valid_reg;
  logic       edge_rise;
  logic       edge_fall;
  logic       ded_event;
  logic       lvl_req;

  // Group change events and gating
  logic [VSX_NUM_GROUPS-1:0] pc_hit;
  logic [4:0]                w1c;
  logic [4:0]                ack_clr;
  logic                      lock_suppress;
  logic                      wr_mcu;

  vsx_unlock_if uif ();

  // ****************************************************************
  // Unlock sequence
  // ****************************************************************

  // Decode of the control writes that drive the unlock timer
  assign wr_mcu     = reg_wr && (reg_addr == VSX_OFS_MCU_CONTROL);
  assign uif.arm    = wr_mcu && reg_wdata[VSX_BIT_UNLOCK];
  assign uif.sel_wr = wr_mcu && !reg_wdata[VSX_BIT_UNLOCK] && uif.armed;
  assign uif.retire = instr_retire;

  vsx_unlock u_unlock (
    .clock (clock),
    .rst_n (rst_n),
    .uif   (uif.tmr)
  );

  // Select only moves inside the unlock window; stray writes are dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vector_sel_reg <= 1'b0;
    end else if (uif.sel_wr) begin
      vector_sel_reg <= reg_wdata[VSX_BIT_SELECT];
    end
  end

  // Vector base follows the select bit
  assign vector_base = vector_sel_reg ? boot_section_base : VSX_APP_BASE;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  // Sense field and enables
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sense_reg  <= VSX_SENSE_LOW;
      enable_reg <= 5'h00;
    end else if (reg_wr) begin
      if (reg_addr == VSX_OFS_SENSE_CTRL) begin
        sense_reg <= vsx_sense_e'(reg_wdata[1:0]);
      end
      if (reg_addr == VSX_OFS_IRQ_ENABLE) begin
        enable_reg <= {reg_wdata[7:4], reg_wdata[VSX_BIT_DED_ENABLE]};
      end
    end
  end

  // Group masks; group three has only seven lines
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < VSX_NUM_GROUPS; g++) begin
        mask_reg[g] <= VSX_RST_BYTE;
      end
    end else if (reg_wr && (reg_addr[7:2] == VSX_OFS_PC_MASK0[7:2])) begin
      mask_reg[reg_addr[1:0]] <= (reg_addr[1:0] == 2'h3) ?
                                 {1'b0, reg_wdata[6:0]} : reg_wdata;
    end
  end

  // ****************************************************************
  // Dedicated line
  // ****************************************************************

  // I/O clock runs awake or in idle only
  assign io_clk_en = !sleep_active || sleep_is_idle;

  // Pin is sampled first, then compared; pin direction is irrelevant
  // First sample seeds both stages, so a pin low at reset is no edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_smp_reg   <= 1'b1;
      pin_prev_reg  <= 1'b1;
      smp_valid_reg <= 1'b0;
    end else if (io_clk_en) begin
      pin_smp_reg   <= dedicated_ext_irq_line;
      pin_prev_reg  <= smp_valid_reg ? pin_smp_reg : dedicated_ext_irq_line;
      smp_valid_reg <= 1'b1;
    end
  end

  // A pulse longer than one period lands in the sample pair while the I/O clock runs
  assign edge_rise = io_clk_en && smp_valid_reg && pin_smp_reg && !pin_prev_reg;
  assign edge_fall = io_clk_en && smp_valid_reg && !pin_smp_reg && pin_prev_reg;

  // Trigger selection by sense mode
  always_comb begin
    case (sense_reg)
      VSX_SENSE_ANY:     ded_event = edge_rise || edge_fall;
      VSX_SENSE_FALLING: ded_event = edge_fall;
      VSX_SENSE_RISING:  ded_event = edge_rise;
      default:           ded_event = 1'b0;
    endcase
  end

  // Level request is unclocked by the I/O clock and waits out start-up
  assign lvl_req = (sense_reg == VSX_SENSE_LOW) && enable_reg[0] &&
                   !dedicated_ext_irq_line && !wake_startup_busy;

  // ****************************************************************
  // Pin-change groups
  // ****************************************************************
  for (genvar g = 0; g < VSX_NUM_GROUPS; g++) begin : g_pc
    localparam int LO = 8 * g;
    localparam int W  = (g == VSX_NUM_GROUPS - 1) ? 7 : 8;
    vsx_pc_group #(
      .WIDTH (W)
    ) u_grp (
      .clock (clock),
      .rst_n (rst_n),
      .pins  (pin_change_inputs[LO +: W]),
      .mask  (mask_reg[g][W-1:0]),
      .hit   (pc_hit[g])
    );
  end

  // ****************************************************************
  // Flags
  // ****************************************************************

  // Clears from a write of one and from service entry
  always_comb begin
    w1c     = 5'h00;
    ack_clr = 5'h00;
    if (reg_wr && (reg_addr == VSX_OFS_IRQ_FLAGS)) begin
      w1c = {reg_wdata[7:4], reg_wdata[VSX_BIT_DED_ENABLE]};
    end
    if (irq_ack && (irq_ack_id <= 3'h4)) begin
      ack_clr[irq_ack_id] = 1'b1;
    end
  end

  // A set in the same cycle as a clear wins
  always_comb begin
    flag_next = flag_reg & ~(w1c | ack_clr);
    flag_next = flag_next | {pc_hit, ded_event};
    if (sense_reg == VSX_SENSE_LOW) begin
      flag_next[0] = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 5'h00;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ****************************************************************
  // Requests toward the core
  // ****************************************************************

  // Boot lock bits suppress interrupts from the section without vectors
  assign lock_suppress = (vector_sel_reg && app_side_lock_bit && !exec_in_boot) ||
                         (!vector_sel_reg && boot_side_lock_bit && exec_in_boot);

  // Blocking is separate from the global enable, which is only read
  assign irq_blocked = uif.blocking || lock_suppress;

  always_comb begin
    irq_req    = enable_reg & flag_reg;
    irq_req[0] = (sense_reg == VSX_SENSE_LOW) ? lvl_req : irq_req[0];
    if (!global_irq_enable || irq_blocked) begin
      irq_req = 5'h00;
    end
  end

  // Wake path ignores the I/O clock so deep sleep can end
  assign wake_req = (sleep_active && !sleep_is_idle) &&
                    (|(pc_hit & enable_reg[4:1]) ||
                     ((sense_reg == VSX_SENSE_LOW) && enable_reg[0] &&
                      !dedicated_ext_irq_line));

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_comb begin
    case (reg_addr)
      VSX_OFS_MCU_CONTROL: rd_mux = {6'h00, vector_sel_reg, uif.armed};
      VSX_OFS_SENSE_CTRL:  rd_mux = {6'h00, sense_reg};
      VSX_OFS_IRQ_ENABLE:  rd_mux = {enable_reg[4:1], 3'h0, enable_reg[0]};
      VSX_OFS_IRQ_FLAGS:   rd_mux = {flag_reg[4:1], 3'h0, flag_reg[0]};
      VSX_OFS_PC_MASK0:    rd_mux = mask_reg[0];
      VSX_OFS_PC_MASK1:    rd_mux = mask_reg[1];
      VSX_OFS_PC_MASK2:    rd_mux = mask_reg[2];
      VSX_OFS_PC_MASK3:    rd_mux = mask_reg[3];
      default:             rd_mux = 8'h00; // Unmapped reads as zero
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_block_masks_req: assert property (@(posedge clock) disable iff (!rst_n)
    irq_blocked |-> (irq_req == 5'h00))
    else $error("request passed while blocked");
  chk_sel_write_ends: assert property (@(posedge clock) disable iff (!rst_n)
    uif.sel_wr |=> !uif.armed && (vector_sel_reg == $past(reg_wdata[VSX_BIT_SELECT]))
                   && uif.blocking)
    else $error("select write did not end unlock or take value");
  chk_vector_base_map: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(vector_sel_reg) |-> $past(uif.armed) &&
      (vector_base == (vector_sel_reg ? boot_section_base : VSX_APP_BASE)))
    else $error("vector select moved outside unlock window");
  chk_level_flag_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (sense_reg == VSX_SENSE_LOW)[*2] |-> !flag_reg[0])
    else $error("dedicated flag set in level mode");
  chk_level_request: assert property (@(posedge clock) disable iff (!rst_n)
    (lvl_req && global_irq_enable && !irq_blocked) |-> irq_req[0])
    else $error("level request missing while pin low");
  chk_startup_gate: assert property (@(posedge clock) disable iff (!rst_n)
    wake_startup_busy |-> !lvl_req)
    else $error("level request during start-up");
  chk_lock_suppress: assert property (@(posedge clock) disable iff (!rst_n)
    lock_suppress |-> (irq_req == 5'h00))
    else $error("request passed from locked section");
  chk_falling_sets: assert property (@(posedge clock) disable iff (!rst_n)
    (edge_fall && sense_reg == VSX_SENSE_FALLING) |=> flag_reg[0])
    else $error("falling edge did not set flag");
  chk_io_clk_sleep: assert property (@(posedge clock) disable iff (!rst_n)
    (sleep_active && !sleep_is_idle) |-> !io_clk_en ##0 !ded_event)
    else $error("edge logic active in deep sleep");
  chk_group_flag: assert property (@(posedge clock) disable iff (!rst_n)
    pc_hit[1] |=> flag_reg[2])
    else $error("group one change did not set flag");

  cov_unlock_move: cover property (@(posedge clock) disable iff (!rst_n)
    uif.arm ##[1:4] uif.sel_wr);
  cov_unlock_timeout: cover property (@(posedge clock) disable iff (!rst_n)
    uif.arm ##1 (!uif.sel_wr && !uif.arm)[*4]);
  cov_pc_service: cover property (@(posedge clock) disable iff (!rst_n)
    irq_req[1] ##[1:8] (irq_ack && irq_ack_id == 3'h1));
  cov_level_wake: cover property (@(posedge clock) disable iff (!rst_n)
    wake_req && (sense_reg == VSX_SENSE_LOW));
  cov_startup_hold: cover property (@(posedge clock) disable iff (!rst_n)
    (wake_startup_busy && !dedicated_ext_irq_line) ##1 lvl_req);

endmodule : vsx_irq_front

// *** testbench/vsx_core_model.sv ***
// Core sequencer model: retires instructions and enters service routines
`timescale 1ns/1ps
module vsx_core_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Requests and bench control
  input  wire logic [4:0] irq_req,
  input  wire logic       ack_en,
  // Core outputs
  output logic            instr_retire,
  output logic            irq_ack,
  output logic [2:0]      irq_ack_id
);
  logic [1:0] cnt_reg;
  // Retire every fourth cycle, slow enough to expose the hold-off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg      <= 2'h0;
      instr_retire <= 1'b0;
    end else begin
      cnt_reg      <= cnt_reg + 2'h1;
      instr_retire <= (cnt_reg == 2'h3);
    end
  end
  // Enter service for the lowest pending request; gap after each
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack    <= 1'b0;
      irq_ack_id <= 3'h0;
    end else begin
      irq_ack    <= ack_en && (irq_req != 5'h00) && !irq_ack;
      irq_ack_id <= irq_req[0] ? 3'h0 : irq_req[1] ? 3'h1 : irq_req[2] ? 3'h2 :
                    irq_req[3] ? 3'h3 : 3'h4;
    end
  end
endmodule : vsx_core_model

// *** testbench/test_vsx_irq_front.sv ***
// Self-checking bench for the interrupt front end
`timescale 1ns/1ps
module test_vsx_irq_front;
  import vsx_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        ded = 1'b1, app_lk = 1'b0, boot_lk = 1'b0, slp = 1'b0, idle = 1'b0;
  logic        gie = 1'b1, in_boot = 1'b0, ack_en = 1'b0, io_en, wake, retire, ack, blk;
  logic        busy = 1'b0;
  logic [30:0] pins = 31'h0;
  logic [2:0]  ack_id;
  logic [4:0]  irq_req;
  logic [15:0] vbase;
  logic [7:0]  exp_q[$];
  int          fails = 0, cmp_count = 0, seed = 32'h6418, idx;
  always #5 clock = ~clock;
  // Device under test; only the boot base is tied
  vsx_irq_front i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dedicated_ext_irq_line(ded), .pin_change_inputs(pins), .app_side_lock_bit(app_lk),
    .boot_side_lock_bit(boot_lk), .boot_section_base(16'h1C00), .sleep_active(slp),
    .sleep_is_idle(idle), .wake_startup_busy(busy), .io_clk_en(io_en), .wake_req(wake),
    .global_irq_enable(gie), .exec_in_boot(in_boot), .instr_retire(retire),
    .irq_ack(ack), .irq_ack_id(ack_id), .irq_req(irq_req), .irq_blocked(blk),
    .vector_base(vbase));
  vsx_core_model i_core (.clock(clock), .rst_n(rst_n), .irq_req(irq_req),
    .ack_en(ack_en), .instr_retire(retire), .irq_ack(ack), .irq_ack_id(ack_id));
  task automatic end_sim;
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (!ok) begin
      fails++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_rd   <= 1'b0;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // Read data stand one cycle after the strobe; oldest note first
  always @(posedge clock) begin
    rd_seen <= reg_rd;
    if (rd_seen) begin
      if (exp_q.size() == 0) chk(1'b0, "read without note");
      else chk(reg_rdata === exp_q.pop_front(), "read data");
    end
  end
  // Watchdog against a hung run
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 9; a++) rd(a[7:0], VSX_RST_BYTE);
    chk(vbase === VSX_APP_BASE, "vector base at reset");
    // Unlock with no select write: window closes after four cycles
    wr(VSX_OFS_MCU_CONTROL, 8'h01);
    #1 chk(blk === 1'b1, "blocked after unlock");
    rd(VSX_OFS_MCU_CONTROL, 8'h01);
    cyc(1);
    chk(blk === 1'b1, "blocked in last window cycle");
    cyc(1);
    chk(blk === 1'b0, "blocked past window");
    rd(VSX_OFS_MCU_CONTROL, 8'h00);
    wr(VSX_OFS_MCU_CONTROL, 8'h02);
    rd(VSX_OFS_MCU_CONTROL, 8'h00);
    // Move to boot, check lock suppression, then move back
    for (int s = 1; s >= 0; s--) begin
      wr(VSX_OFS_MCU_CONTROL, 8'h01);
      wr(VSX_OFS_MCU_CONTROL, 8'(s * 2));
      #1 chk(blk === 1'b1, "blocked after select write");
      rd(VSX_OFS_MCU_CONTROL, 8'(s * 2));
      chk(vbase === (s ? 16'h1C00 : VSX_APP_BASE), "vector base");
      cyc(12);
      chk(blk === 1'b0, "hold-off released");
      app_lk  <= s[0];
      boot_lk <= !s[0];
      in_boot <= !s[0];
      cyc(1);
      chk(blk === 1'b1, "lock suppression");
      in_boot <= s[0];
      cyc(1);
      chk(blk === 1'b0, "lock released by other section");
    end
    app_lk  <= 1'b0;
    boot_lk <= 1'b0;
    in_boot <= 1'b0;
    // Pin-change groups 0 and 1, a masked line then an enabled one
    wr(VSX_OFS_IRQ_ENABLE, 8'h31);
    for (int g = 0; g < 2; g++) begin
      idx = $unsigned($random(seed)) % 8;
      wr(VSX_OFS_PC_MASK0 + 8'(g), 8'h01 << idx);
      pins[g * 8 + (idx + 1) % 8] <= ~pins[g * 8 + (idx + 1) % 8];
      cyc(4);
      rd(VSX_OFS_IRQ_FLAGS, 8'h00);
      pins[g * 8 + idx] <= ~pins[g * 8 + idx];
      cyc(4);
      chk(irq_req[1 + g] === 1'b1, "group request");
      rd(VSX_OFS_IRQ_FLAGS, 8'h10 << g);
      ack_en <= 1'b1;
      for (int t = 0; t < 20 && ack !== 1'b1; t++) cyc(1);
      chk(ack === 1'b1, "service entry");
      ack_en <= 1'b0;
      cyc(2);
      rd(VSX_OFS_IRQ_FLAGS, 8'h00);
      wr(VSX_OFS_PC_MASK0 + 8'(g), 8'h00);
    end
    // Edge modes any change, falling, rising: each drives a fall then a rise, flag cleared by writing one
    for (int m = 1; m < 4; m++) begin
      wr(VSX_OFS_SENSE_CTRL, 8'(m));
      wr(VSX_OFS_IRQ_FLAGS, 8'hFF);
      for (int e = 0; e < 2; e++) begin
        ded <= e[0];
        cyc(3);
        rd(VSX_OFS_IRQ_FLAGS, 8'(m != 3 - e));
        wr(VSX_OFS_IRQ_FLAGS, 8'h01);
      end
    end
    // Level mode: request follows the pin, flag stays zero
    wr(VSX_OFS_SENSE_CTRL, 8'h00);
    ded <= 1'b0;
    cyc(3);
    chk(irq_req[0] === 1'b1, "level request");
    rd(VSX_OFS_IRQ_FLAGS, 8'h00);
    slp <= 1'b1;
    cyc(1);
    chk(io_en === 1'b0 && wake === 1'b1, "deep sleep wake");
    // Start-up running: wake stands, level request held back
    busy <= 1'b1;
    cyc(1);
    chk(wake === 1'b1 && irq_req[0] === 1'b0, "level gated in start-up");
    // Source keeps the pin low through start-up
    busy <= 1'b0;
    cyc(1);
    chk(irq_req[0] === 1'b1, "level held past start-up");
    idle <= 1'b1;
    cyc(1);
    chk(io_en === 1'b1 && wake === 1'b0, "idle sleep");
    slp <= 1'b0;
    ded <= 1'b1;
    cyc(1);
    chk(irq_req[0] === 1'b0, "level released");
    cyc(2);
    end_sim();
  end
endmodule : test_vsx_irq_front
